// ### sbs_sram.sv
// synchronous pipelined burst sram: cycle decode, burst, writes, sleep
// assumes all pins but rst_b, sleep_request and out_enable_n are synchronous to clk
//
// Operation
// RULE_01: processor strobe start captures address, ignores writes
// RULE_02: processor write completes at second edge
// RULE_03: byte write stores only selected lanes
// RULE_04: controller strobe write completes in one cycle
// RULE_05: controller start loads address, ignores advance
// RULE_06: data pins released whenever a write detected
// RULE_07: master raises output enable before driving data
// RULE_08: two-bit burst counter, interleaved or linear
// RULE_09: advance low steps the burst counter
// RULE_10: interleaved order xors start with beat
// RULE_11: linear order adds beat modulo four
// RULE_12: sleep pin asynchronous, sleep releases data pins
// RULE_13: two cycles to enter and leave sleep
// RULE_14: contents kept in sleep, pending access dropped
// RULE_15: master deselects before requesting sleep
// RULE_16: master stays idle two cycles after sleep
// RULE_17: output enable gates drivers without clocking
// RULE_18: processor strobe ignored when first select high
// RULE_19: read data leaves output register next edge
// RULE_20: first cycle after deselect masked; deselect releases
// RULE_21: strobes high: advance steps, otherwise suspend
// RULE_22: bad select with a strobe deselects device
`timescale 1ns/100ps
`default_nettype none

module sbs_sram
#(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int LANES  = sbs_pkg::LANES,
  parameter int LANE_W = sbs_pkg::LANE_W
)
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // address and strobes
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic                      proc_addr_strobe_n,
  input  wire logic                      ctrl_addr_strobe_n,
  input  wire logic                      burst_step_n,
  input  wire logic                      burst_linear,
  // chip selects
  input  wire logic                      chip_sel_one_n,
  input  wire logic                      chip_sel_two,
  input  wire logic                      chip_sel_three_n,
  // write controls
  input  wire logic                      global_write_n,
  input  wire logic                      byte_write_gate_n,
  input  wire logic [LANES-1:0]          byte_lane_select_n,
  // data pins
  input  wire logic [LANES*LANE_W-1:0]   dq_in,
  output logic      [LANES*LANE_W-1:0]   dq_out,
  output logic                           dq_oe,
  input  wire logic                      out_enable_n,
  // sleep and array write port
  input  wire logic                      sleep_request,
  output logic                           sleep_state,
  output logic                           write_buf_ready,
  input  wire logic                      core_hold
);

  localparam int DW = LANES * LANE_W;
  localparam int EW = ADDR_W + LANES + DW;
  localparam int BW = sbs_pkg::BURST_W;

  typedef struct packed
  {
    logic              active;
    logic              first;
    logic [ADDR_W-1:0] base;
    logic              rd_pend;
    logic [ADDR_W-1:0] rd_addr;
    logic              rd_show;
    logic [DW-1:0]     dout;
    logic              zz_meta;
    logic              zz;
  } sbs_st_t;

  sbs_st_t st;
  sbs_st_t next_st;

  logic             rst_meta;
  logic             rst_n;
  logic             sel_all;
  logic             proc_addr_strobe_n_start;
  logic             ctrl_addr_strobe_n_start;
  logic             start;
  logic             desel;
  logic             cont;
  logic             wr_req;
  logic [LANES-1:0] lanes;
  logic             push;
  logic             rd_issue;
  logic [ADDR_W-1:0] issue_addr;
  logic [BW-1:0]    beat;
  logic [BW-1:0]    cur_lsb;
  logic [BW-1:0]    next_lsb;
  logic [ADDR_W-1:0] burst_addr;
  logic [EW-1:0]    wb_in;
  logic [EW-1:0]    wb_out;
  logic             wb_valid;
  logic             wb_pop;
  logic [DW-1:0]    rd_word;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign sleep_state = st.zz;

  // cycle decode on the sampled pins
  always_comb
  begin
    sel_all    = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
    // processor strobe only counts with the first select low
    proc_addr_strobe_n_start = !st.zz && !proc_addr_strobe_n && sel_all;                 // see RULE_01 see RULE_18
    ctrl_addr_strobe_n_start = !st.zz && !ctrl_addr_strobe_n && proc_addr_strobe_n && sel_all;
    start      = proc_addr_strobe_n_start || ctrl_addr_strobe_n_start;
    desel      = !st.zz && ((chip_sel_one_n && !ctrl_addr_strobe_n)
               || (!chip_sel_one_n && !sel_all
                   && (!proc_addr_strobe_n || !ctrl_addr_strobe_n)));   // see RULE_22
    cont       = !st.zz && st.active && ctrl_addr_strobe_n
               && (proc_addr_strobe_n || chip_sel_one_n);
    wr_req     = !global_write_n
               || (!byte_write_gate_n && (byte_lane_select_n != '1));
    if (!global_write_n)
      lanes = '1;                                                          // see RULE_02
    else if (!byte_write_gate_n)
      lanes = ~byte_lane_select_n;                                         // see RULE_03
    else
      lanes = '0;
    // advance low uses the next burst slot, high holds the current one
    burst_addr = {st.base[ADDR_W-1:BW], (burst_step_n ? cur_lsb : next_lsb)}; // see RULE_21
    // write controls only matter on a controller start or a later cycle
    push       = (ctrl_addr_strobe_n_start || cont) && wr_req;                // see RULE_01 see RULE_02 see RULE_04
    rd_issue   = proc_addr_strobe_n_start || ((ctrl_addr_strobe_n_start || cont) && !wr_req);
    issue_addr = start ? addr : burst_addr;                                 // see RULE_05
  end

  sbs_burst u_burst
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (start),
    .step     (cont && !burst_step_n),                                      // see RULE_09
    .linear   (burst_linear),
    .start    (st.base[BW-1:0]),
    .beat     (beat),
    .cur_lsb  (cur_lsb),
    .next_lsb (next_lsb)
  );

  // writes queue here so a held array never stalls the pin timing
  assign wb_in = {issue_addr, lanes, dq_in};

  sbs_fifo #(.WIDTH(EW), .DEPTH(sbs_pkg::WBUF_DEPTH)) u_wbuf
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (write_buf_ready),
    .in_data   (wb_in),
    .out_valid (wb_valid),
    .out_ready (!core_hold),
    .out_data  (wb_out)
  );

  assign wb_pop = wb_valid && !core_hold;

  // one array per byte lane so unselected lanes are never touched
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [LANE_W-1:0] lane_mem [2**ADDR_W];
      always_ff @(posedge clk)
      begin
        if (wb_pop && wb_out[DW+g])
          lane_mem[wb_out[EW-1 -: ADDR_W]] <= wb_out[g*LANE_W +: LANE_W];  // see RULE_03
      end
      assign rd_word[g*LANE_W +: LANE_W] = lane_mem[st.rd_addr];
    end
  endgenerate

  always_comb
  begin
    next_st         = st;
    // sleep pin passes two flops: two edges to enter and to leave
    next_st.zz_meta = sleep_request;                                        // see RULE_12
    next_st.zz      = st.zz_meta;                                           // see RULE_13
    if (st.zz || desel)
      next_st.active = 1'b0;                                                // see RULE_14
    else if (start)
      next_st.active = 1'b1;
    next_st.first   = start && !st.active;                                  // see RULE_20
    if (start)
      next_st.base = addr;                                                  // see RULE_01 see RULE_05
    next_st.rd_pend = rd_issue;
    next_st.rd_addr = issue_addr;
    next_st.rd_show = st.rd_pend && !desel && !st.zz;                       // see RULE_19
    if (st.rd_pend)
      next_st.dout = rd_word;                                               // see RULE_19
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{active: 1'b0, first: 1'b0, base: sbs_pkg::ADDR_RST, rd_pend: 1'b0,
              rd_addr: sbs_pkg::ADDR_RST, rd_show: 1'b0, dout: sbs_pkg::DATA_RST,
              zz_meta: 1'b0, zz: 1'b0};
    else
      st <= next_st;
  end

  // output enable acts without sampling; write, deselect or sleep forces release
  assign dq_oe  = st.rd_show && !out_enable_n && !st.first && !push
                && !desel && !st.zz;                       // see RULE_06 see RULE_12 see RULE_17
  assign dq_out = st.dout;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_proc_addr_strobe_n_start;
    proc_addr_strobe_n_start && !push;
  endsequence

  // advance high on the second edge keeps the write at the start address
  sequence s_gw_next;
    cont && burst_step_n && !global_write_n;
  endsequence

  property p_proc_addr_strobe_n_ignores_write;
    proc_addr_strobe_n_start |-> !push && rd_issue;
  endproperty
  a_proc_addr_strobe_n_ignores_write: assert property (p_proc_addr_strobe_n_ignores_write) else $error("write on strobe cycle"); // see RULE_01

  property p_gw_second_edge;
    s_proc_addr_strobe_n_start ##1 s_gw_next |-> push && lanes == '1 && issue_addr == $past(addr);
  endproperty
  a_gw_second_edge: assert property (p_gw_second_edge) else $error("global write missed"); // see RULE_02

  property p_byte_lanes;
    push && global_write_n |-> lanes == ~byte_lane_select_n && !byte_write_gate_n;
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("wrong byte lanes"); // see RULE_03

  property p_ctrl_addr_strobe_n_write;
    ctrl_addr_strobe_n_start && wr_req |-> push && issue_addr == addr;
  endproperty
  a_ctrl_addr_strobe_n_write: assert property (p_ctrl_addr_strobe_n_write) else $error("controller write lost"); // see RULE_04

  property p_ctrl_addr_strobe_n_beat;
    ctrl_addr_strobe_n_start |=> beat == 2'h0 && st.base == $past(addr);
  endproperty
  a_ctrl_addr_strobe_n_beat: assert property (p_ctrl_addr_strobe_n_beat) else $error("burst not loaded"); // see RULE_05

  property p_write_release;
    push |-> !dq_oe;
  endproperty
  a_write_release: assert property (p_write_release) else $error("driving during write"); // see RULE_06

  property p_step;
    cont && !burst_step_n && !start |=> beat == $past(beat) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("burst did not step"); // see RULE_09

  property p_suspend;
    cont && burst_step_n |=> beat == $past(beat);
  endproperty
  a_suspend: assert property (p_suspend) else $error("burst moved on suspend"); // see RULE_21

  property p_interleave;
    start && !burst_linear && addr[1:0] == 2'h1 ##1 cont && !burst_step_n && !burst_linear
      |-> issue_addr[1:0] == 2'h0;
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave order wrong"); // see RULE_10

  property p_linear;
    start && burst_linear && addr[1:0] == 2'h1 ##1 cont && !burst_step_n && burst_linear
      |-> issue_addr[1:0] == 2'h2;
  endproperty
  a_linear: assert property (p_linear) else $error("linear order wrong"); // see RULE_11

  property p_sleep_entry;
    $rose(sleep_request) ##1 sleep_request |=> sleep_state;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry late"); // see RULE_13

  property p_sleep_hiz;
    sleep_state |-> !dq_oe && !push;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("active in sleep"); // see RULE_12

  property p_oe_gate;
    dq_oe |-> !out_enable_n && st.rd_show;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drive without enable"); // see RULE_17

  property p_read_pipe;
    rd_issue && !start ##1 !desel && !sleep_state |=> st.rd_show;
  endproperty
  a_read_pipe: assert property (p_read_pipe) else $error("read data not shown"); // see RULE_19

  property p_deselect;
    desel |-> !dq_oe ##1 !st.active && !st.rd_show;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect kept driving"); // see RULE_20 see RULE_22

  property p_ce1_proc_addr_strobe_n;
    chip_sel_one_n && ctrl_addr_strobe_n |-> !start;
  endproperty
  a_ce1_proc_addr_strobe_n: assert property (p_ce1_proc_addr_strobe_n) else $error("strobe not ignored"); // see RULE_18

  property p_sleep_exit;
    $fell(sleep_request) ##1 !sleep_request |=> !sleep_state;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit late"); // see RULE_13

  property p_proc_addr_strobe_n_load;
    proc_addr_strobe_n_start |=> beat == sbs_pkg::BEAT_RST && cur_lsb == $past(addr[1:0]);
  endproperty
  a_proc_addr_strobe_n_load: assert property (p_proc_addr_strobe_n_load) else $error("burst start not loaded"); // see RULE_01 see RULE_08

  property p_bad_select;
    !sleep_state && !chip_sel_one_n && chip_sel_three_n && !proc_addr_strobe_n |-> desel && !start;
  endproperty
  a_bad_select: assert property (p_bad_select) else $error("bad select not deselected"); // see RULE_22

  property p_first_mask;
    st.first |-> !dq_oe;
  endproperty
  a_first_mask: assert property (p_first_mask) else $error("drive on first cycle"); // see RULE_20

endmodule
`default_nettype wire

// ### sbs_pkg.sv
// constants shared by the burst sram access logic
// assumes one 20 MHz clock; no bus, every control is a pin
package sbs_pkg;

  // array geometry
  localparam int ADDR_W   = 18;
  localparam int LANES    = 4;
  localparam int LANE_W   = 9;
  localparam int DATA_W   = LANES * LANE_W;
  localparam int BURST_W  = 2;

  // write buffer between the pins and the array
  localparam int WBUF_DEPTH = 8;

  // timing: the sleep entry and recovery time is two clock periods
  localparam int CLK_PERIOD_NS       = 50;
  localparam int SLEEP_ENTRY_TIME_NS = 2 * CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC     = (SLEEP_ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // values after reset, and the burst step
  localparam logic [BURST_W-1:0] BEAT_RST  = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 18'h00000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 36'h000000000;

endpackage

// ### sbs_burst.sv
// two-bit wraparound burst counter with interleaved or linear order
// assumes the start offset is held stable by the caller during a burst
`timescale 1ns/100ps
`default_nettype none

module sbs_burst
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // control
  input  wire logic                        load,
  input  wire logic                        step,
  input  wire logic                        linear,
  input  wire logic [sbs_pkg::BURST_W-1:0] start,
  // burst offsets
  output logic      [sbs_pkg::BURST_W-1:0] beat,
  output logic      [sbs_pkg::BURST_W-1:0] cur_lsb,
  output logic      [sbs_pkg::BURST_W-1:0] next_lsb
);

  typedef struct packed
  {
    logic [sbs_pkg::BURST_W-1:0] beat;
  } sbs_burst_st_t;

  sbs_burst_st_t st;
  sbs_burst_st_t next_st;
  logic [sbs_pkg::BURST_W-1:0] beat_nx;

  always_comb
  begin
    beat_nx  = st.beat + sbs_pkg::BEAT_STEP;
    // interleaved xors the beat in, linear adds it modulo four
    cur_lsb  = linear ? start + st.beat : start ^ st.beat;     // see RULE_10 see RULE_11
    next_lsb = linear ? start + beat_nx : start ^ beat_nx;     // see RULE_10 see RULE_11
    next_st  = st;
    if (load)
      next_st.beat = sbs_pkg::BEAT_RST;                        // see RULE_08
    else if (step)
      next_st.beat = beat_nx;                                  // see RULE_09
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{beat: sbs_pkg::BEAT_RST};
    else
      st <= next_st;
  end

  assign beat = st.beat;

endmodule
`default_nettype wire

// ### sbs_fifo.sv
// small write buffer: parameterised width and depth, valid/ready both sides
// assumes a single clock and an active-low reset already synchronised
`timescale 1ns/100ps
`default_nettype none

module sbs_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = sbs_pkg::WBUF_DEPTH
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   cnt;
  } sbs_fifo_st_t;

  sbs_fifo_st_t   st;
  sbs_fifo_st_t   next_st;
  logic [WIDTH-1:0] store [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = store[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
      next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    if (pop)
      next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // storage carries no reset; only the pointers and the fill count decide what is valid
  always_ff @(posedge clk)
  begin
    if (push)
      store[st.wr] <= in_data;
  end

endmodule
`default_nettype wire

// ### sbs_master.sv
// bus master model for the burst sram pins, one call of cyc per clock
// assumes a single caller; the data pin level is resolved here
`timescale 1ns/100ps
`default_nettype none

module sbs_master
(
  // clock
  input  wire logic                         clk,
  // address, strobes, selects
  output logic      [sbs_pkg::ADDR_W-1:0]   addr,
  output logic                              proc_addr_strobe_n,
  output logic                              ctrl_addr_strobe_n,
  output logic                              burst_step_n,
  output logic                              chip_sel_one_n,
  output logic                              chip_sel_two,
  output logic                              chip_sel_three_n,
  // write controls
  output logic                              global_write_n,
  output logic                              byte_write_gate_n,
  output logic      [sbs_pkg::LANES-1:0]    byte_lane_select_n,
  // data pins, output enable, sleep
  output logic      [sbs_pkg::DATA_W-1:0]   dq_in,
  input  wire logic [sbs_pkg::DATA_W-1:0]   dq_out,
  input  wire logic                         dq_oe,
  output logic                              out_enable_n,
  output logic                              sleep_request
);
  logic [sbs_pkg::DATA_W-1:0] wdata;
  logic [sbs_pkg::DATA_W-1:0] last_pin;
  logic                       drive;

  // a released pin shows the inverse of its last level, so stale data never matches
  always_comb dq_in = dq_oe ? dq_out : (drive ? wdata : ~last_pin);
  always_ff @(posedge clk) last_pin <= dq_in;

  initial
  begin
    {addr, wdata} = '0;
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, chip_sel_one_n} = 4'hf;
    {global_write_n, byte_write_gate_n, out_enable_n} = 3'h7;
    byte_lane_select_n = 4'hf;
    chip_sel_two = 1'b1;
    chip_sel_three_n = 1'b0;
    drive = 1'b0;
    sleep_request = 1'b0;
  end

  // kinds: 0 deselect, 1 proc start, 2 ctrl read, 3 ctrl write, 4 proc write data,
  // 5 continue, 6 suspend, 7 rest, 8 ctrl byte write
  task automatic cyc(input int k, input logic [17:0] a, input logic [3:0] ln,
                     input logic [35:0] d);
    @(posedge clk);
    proc_addr_strobe_n <= !(k == 1);
    ctrl_addr_strobe_n <= !(k == 0 || k == 2 || k == 3 || k == 8);
    chip_sel_one_n     <= (k == 0 || k == 7);
    burst_step_n       <= !(k < 4 || k == 5 || k == 8);
    global_write_n     <= !(k == 1 || k == 3 || k == 4);
    byte_write_gate_n  <= (k != 8);
    byte_lane_select_n <= ln;
    out_enable_n       <= !(k == 5 || k == 6);
    drive              <= (k == 3 || k == 4 || k == 8);
    wdata              <= d;
    if (k < 4 || k == 8)
      addr <= a;
  endtask

  task automatic set_sleep(input logic v);
    @(posedge clk);
    sleep_request <= v;
  endtask

endmodule

`default_nettype wire

// ### sbs_sram_test.sv
// self-checking bench for the burst sram: writes, bursts, buffer, sleep
// assumes sbs_master stands on the pins; bench owns clock, reset, core_hold
`timescale 1ns/100ps
`default_nettype none

module sbs_sram_test;
  typedef struct packed {logic [3:0] k; logic [17:0] a; logic [3:0] ln; logic [35:0] d;} sbs_row_t;
  logic        clk, rst_b, core_hold, burst_linear;
  logic [17:0] addr;
  logic        proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
  logic        chip_sel_one_n, chip_sel_two, chip_sel_three_n;
  logic        global_write_n, byte_write_gate_n, out_enable_n, sleep_request;
  logic [3:0]  byte_lane_select_n;
  logic [35:0] dq_in, dq_out;
  logic        dq_oe, sleep_state, write_buf_ready;
  int          err_total, checks_done;
  logic [35:0] ref_mem [logic [17:0]];
  sbs_row_t    rows [7] = '{'{4'h1, 18'h00100, 4'h0, 36'h123456789},
                            '{4'h3, 18'h00101, 4'h0, 36'h2468ace01},
                            '{4'h1, 18'h00102, 4'h0, 36'h3c3c3c3c3},
                            '{4'h3, 18'h00103, 4'h0, 36'h4a5b6c7d8},
                            '{4'h2, 18'h00100, 4'h0, 36'h0},
                            '{4'h2, 18'h00101, 4'h0, 36'h0},
                            '{4'h2, 18'h00102, 4'h0, 36'h0}};

  sbs_sram dut (.clk(clk), .rst_b(rst_b), .addr(addr), .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_step_n(burst_step_n),
    .burst_linear(burst_linear), .chip_sel_one_n(chip_sel_one_n), .chip_sel_two(chip_sel_two),
    .chip_sel_three_n(chip_sel_three_n), .global_write_n(global_write_n),
    .byte_write_gate_n(byte_write_gate_n), .byte_lane_select_n(byte_lane_select_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .out_enable_n(out_enable_n),
    .sleep_request(sleep_request), .sleep_state(sleep_state),
    .write_buf_ready(write_buf_ready), .core_hold(core_hold));

  sbs_master m (.clk(clk), .addr(addr), .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_step_n(burst_step_n),
    .chip_sel_one_n(chip_sel_one_n), .chip_sel_two(chip_sel_two),
    .chip_sel_three_n(chip_sel_three_n), .global_write_n(global_write_n),
    .byte_write_gate_n(byte_write_gate_n), .byte_lane_select_n(byte_lane_select_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .out_enable_n(out_enable_n),
    .sleep_request(sleep_request));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chkd(input logic [35:0] got, input logic [35:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string msg);
    chkd({35'h0, got}, {35'h0, exp}, msg);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] k, input logic [17:0] a, input logic [3:0] ln,
                    input logic [35:0] d);
    if (k == 4'h1)
      m.cyc(1, a, 4'hf, ~d);
    m.cyc(k == 4'h1 ? 4 : int'(k), a, ln, d);
    m.cyc(0, a, 4'hf, '0);
    if (!ref_mem.exists(a))
      ref_mem[a] = d;
    for (int i = 0; i < 4; i++)
      if (k != 4'h8 || !ln[i])
        ref_mem[a][9*i +: 9] = d[9*i +: 9];
  endtask

  task automatic rd(input logic [17:0] a);
    m.cyc(2, a, 4'hf, '0);
    m.cyc(6, a, 4'hf, '0);
    #1 chkb(dq_oe, 1'b0, "oe on first cycle");
    m.cyc(6, a, 4'hf, '0);
    #1 chkd(dq_out, ref_mem[a], "read data");
    chkb(dq_oe, 1'b1, "oe on read");
    m.cyc(0, a, 4'hf, '0);
    #1 chkb(dq_oe, 1'b0, "oe on deselect");
  endtask

  task automatic burst(input logic lin, input logic [17:0] a);
    logic [1:0] s;
    burst_linear <= lin;
    m.cyc(2, a, 4'hf, '0);
    for (int b = 0; b < 5; b++)
    begin
      m.cyc(b < 3 ? 5 : 6, a, 4'hf, '0);
      s = lin ? a[1:0] + 2'(b - 1) : a[1:0] ^ 2'(b - 1);
      if (b > 0)
        #1 chkd(dq_out, ref_mem[{a[17:2], s}], "burst beat");
    end
    m.cyc(0, a, 4'hf, '0);
  endtask

  initial
  begin
    rst_b = 1'b0;
    core_hold = 1'b0;
    burst_linear = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    #1 chkb(dq_oe, 1'b0, "reset oe");
    chkb(sleep_state, 1'b0, "reset sleep");
    chkb(write_buf_ready, 1'b1, "reset ready");
    @(posedge clk) rst_b <= 1'b1;
    repeat (3) m.cyc(0, '0, 4'hf, '0);
    foreach (rows[i])
      if (rows[i].k == 4'h2)
        rd(rows[i].a);
      else
        wr(rows[i].k, rows[i].a, rows[i].ln, rows[i].d);
    // every lane pattern over one word, each read back
    wr(4'h3, 18'h00105, 4'h0, 36'h0);
    for (int p = 0; p < 16; p++)
    begin
      wr(4'h8, 18'h00105, 4'(p), {4{4'(p), 5'h15}});
      rd(18'h00105);
    end
    burst(1'b0, 18'h00101);
    burst(1'b1, 18'h00101);
    burst(1'b0, 18'h00102);
    burst(1'b1, 18'h00103);
    // fill the write buffer with the array stalled, then one write too many
    core_hold <= 1'b1;
    for (int i = 0; i < 8; i++)
      wr(4'h3, 18'h00110 + 18'(i), 4'h0, {4{9'(i + 3)}});
    #1 chkb(write_buf_ready, 1'b0, "buffer full");
    m.cyc(3, 18'h00110, 4'h0, 36'hfedcba987);
    m.cyc(0, '0, 4'hf, '0);
    core_hold <= 1'b0;
    for (int n = 0; n < 40 && write_buf_ready !== 1'b1; n++)
    begin
      m.cyc(0, '0, 4'hf, '0);
      #1;
    end
    chkb(write_buf_ready, 1'b1, "buffer drain");
    repeat (10) m.cyc(0, '0, 4'hf, '0);
    for (int i = 0; i < 8; i++)
      rd(18'h00110 + 18'(i));
    // sleep entry and exit, deselected beforehand
    m.cyc(7, '0, 4'hf, '0);
    m.set_sleep(1'b1);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
        m.set_sleep(1'b0);
      m.cyc(7, '0, 4'hf, '0);
      #1 chkb(sleep_state, i == 1 || i == 2, "sleep state");
      chkb(dq_oe, 1'b0, "oe in sleep");
    end
    repeat (2) m.cyc(7, '0, 4'hf, '0);
    rd(18'h00100);
    rd(18'h00113);
    results;
  end

endmodule

`default_nettype wire
